// File: pio_error_detect_log.sv
// PIO load/store error detection, logging and response steering
`timescale 1ns/10ps
module pio_error_detect_log (
    input  wire logic        i_sys_clk,
    input  wire logic        i_reset_n,
    // Request side, sampled once per request
    input  wire logic        i_req_valid,
    input  wire logic        i_req_is_store,
    input  wire logic [7:0]  i_req_etag,
    input  wire logic [4:0]  i_req_type,
    input  wire logic [2:0]  i_req_cpu,
    input  wire logic [2:0]  i_req_thread,
    input  wire logic [39:0] i_req_addr,
    input  wire logic        i_req_ue,
    input  wire logic        i_req_data_par,
    input  wire logic        i_dma_fifo_par,
    input  wire logic        i_dispatch_par,
    // Load return from the I/O interface
    input  wire logic        i_ret_valid,
    input  wire logic [7:0]  i_ret_etag,
    input  wire logic [15:0] i_ret_tag,
    input  wire logic [39:0] i_ret_addr,
    input  wire logic [31:0] i_ret_pkt,
    input  wire logic        i_iface_ue,
    input  wire logic        i_iface_tag_ce,
    input  wire logic        i_tag_ue,
    input  wire logic        i_tag_ce,
    input  wire logic        i_data_par,
    input  wire logic        i_ret_fifo_err,
    input  wire logic        i_token_valid,
    input  wire logic        i_token_par,
    // Register port
    input  wire logic [3:0]  i_addr,
    input  wire logic [31:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [31:0] o_rdata,
    // Responses
    output logic             o_resp_valid,
    output logic             o_resp_is_ack,
    output logic      [1:0]  o_resp_err,
    output logic      [2:0]  o_resp_cpu,
    output logic      [2:0]  o_resp_thread,
    output logic             o_dma_cancel,
    output logic             o_warm_reset,
    output logic             o_trap,
    output logic      [1:0]  o_core_error_status
);
    // ========================================
    // State
    typedef struct packed {
        logic [63:0] soc_error_status;
        logic [63:0] fatal_en;
        logic        error_irq_enable;
        logic [7:0]  usyn_etag;
        logic [4:0]  usyn_type;
        logic [2:0]  usyn_cpu;
        logic [2:0]  usyn_thread;
        logic [39:0] usyn_addr;
        logic [15:0] usyn_tag;
        logic [7:0]  isyn_etag;
        logic [15:0] isyn_tag;
        logic [39:0] isyn_addr;
        logic [2:0]  pend_cpu;
        logic [2:0]  pend_thread;
        logic [31:0] rdata;
        logic        resp_valid;
        logic        resp_is_ack;
        logic [1:0]  resp_err;
        logic [2:0]  resp_cpu;
        logic [2:0]  resp_thread;
        logic        dma_cancel;
        logic        warm_reset;
        logic        trap;
        logic [1:0]  core_status;
    } state_t;

    state_t      s_q;
    state_t      s_d;
    logic [63:0] set_bits;
    logic        pkt_ue;
    logic        is_load;
    logic        is_store;

    assign is_load  = i_req_valid & ~i_req_is_store;
    assign is_store = i_req_valid & i_req_is_store;

    pio_err_class u_class (
        .i_is_load      (is_load),
        .i_is_store     (is_store),
        .i_req_ue       (i_req_ue),
        .i_req_data_par (i_req_data_par),
        .i_dma_fifo_par (i_dma_fifo_par),
        .i_ret_fifo_err (i_ret_fifo_err),
        .i_ret_valid    (i_ret_valid),
        .i_iface_ue     (i_iface_ue),
        .i_iface_tag_ce (i_iface_tag_ce),
        .i_tag_ue       (i_tag_ue),
        .i_tag_ce       (i_tag_ce),
        .i_data_par     (i_data_par),
        .i_dispatch_par (i_dispatch_par),
        .i_token_valid  (i_token_valid),
        .i_token_par    (i_token_par),
        .i_pkt          (i_ret_pkt),
        .o_set          (set_bits),
        .o_pkt_ue       (pkt_ue)
    );

    // ========================================
    // Next state
    always_comb begin
        logic        fatal;
        logic        any_new;
        logic        has_ue;
        logic        has_ce;
        logic        no_resp;
        logic [63:0] clr;
        fatal   = |(set_bits & s_q.fatal_en);
        any_new = |set_bits;
        has_ce  = set_bits[pio_err_pkg::BIT_IFACE_TAG_CE] | set_bits[pio_err_pkg::BIT_UNIT_TAG_CE];
        has_ue  = any_new & ~has_ce;
        no_resp = set_bits[pio_err_pkg::BIT_RET_FIFO_UE] | set_bits[pio_err_pkg::BIT_REQ_UE] |
                  set_bits[pio_err_pkg::BIT_TAG_UE] | set_bits[pio_err_pkg::BIT_IFACE_UE];
        clr     = '0;
        s_d = s_q;
        s_d.resp_valid  = 1'b0;
        s_d.resp_is_ack = 1'b0;
        s_d.resp_err    = pio_err_pkg::ERR_NONE;
        s_d.dma_cancel  = 1'b0;
        s_d.trap        = 1'b0;
        s_d.rdata       = '0;

        // Register writes; clearing is write-one-to-clear
        if (i_wr) begin
            case (i_addr)
                pio_err_pkg::OFF_STAT_LO:  clr[31:0]            = i_wdata;
                pio_err_pkg::OFF_STAT_HI:  clr[63:32]           = i_wdata;
                pio_err_pkg::OFF_FATAL_LO: s_d.fatal_en[31:0]   = i_wdata;
                pio_err_pkg::OFF_FATAL_HI: s_d.fatal_en[63:32]  = i_wdata;
                pio_err_pkg::OFF_EIE:      s_d.error_irq_enable = i_wdata[0];
                default: ;
            endcase
        end
        // New events win over a clear in the same cycle
        s_d.soc_error_status = (s_q.soc_error_status & ~clr) | set_bits;

        // Syndrome capture: requester fields
        if (set_bits[pio_err_pkg::BIT_REQ_UE] | set_bits[pio_err_pkg::BIT_DMA_FIFO_UE] |
            (is_load & set_bits[pio_err_pkg::BIT_REQ_DATA_PAR])) begin
            s_d.usyn_etag   = i_req_etag;
            s_d.usyn_type   = i_req_type;
            s_d.usyn_cpu    = i_req_cpu;
            s_d.usyn_thread = i_req_thread;
            s_d.usyn_addr   = i_req_addr;
        end
        if (set_bits[pio_err_pkg::BIT_TAG_UE] | set_bits[pio_err_pkg::BIT_DATA_PAR]) begin
            s_d.usyn_tag = i_ret_tag;
        end
        if (set_bits[pio_err_pkg::BIT_IFACE_UE]) begin
            s_d.isyn_etag = i_ret_etag;
            s_d.isyn_tag  = i_ret_tag;
            s_d.isyn_addr = i_ret_addr;
        end

        // Remember the requester so a later return can be steered back
        if (i_req_valid) begin
            s_d.pend_cpu    = i_req_cpu;
            s_d.pend_thread = i_req_thread;
        end

        // Response selection; a requester left hung is meant to be caught by the fatal path
        if (fatal) begin
            s_d.warm_reset = 1'b1;
        end else if (!no_resp) begin
            if (i_req_valid && (i_dma_fifo_par || i_req_data_par || i_dispatch_par)) begin
                s_d.resp_valid  = 1'b1;
                s_d.resp_is_ack = i_req_is_store;
                s_d.resp_cpu    = i_req_cpu;
                s_d.resp_thread = i_req_thread;
                if (i_req_is_store) begin
                    // Store data parity: uncorrectable indication; FIFO parity: clean ack
                    s_d.resp_err = i_req_data_par ? pio_err_pkg::ERR_UNCORR
                                                  : pio_err_pkg::ERR_NONE;
                end else if (i_dma_fifo_par || i_dispatch_par) begin
                    s_d.resp_err = pio_err_pkg::ERR_UNCORR;
                end else begin
                    s_d.resp_err = pio_err_pkg::ERR_NONE;
                end
            end else if (i_ret_valid) begin
                s_d.resp_valid  = 1'b1;
                s_d.resp_cpu    = s_q.pend_cpu;
                s_d.resp_thread = s_q.pend_thread;
                if (pkt_ue || set_bits[pio_err_pkg::BIT_DATA_PAR]) begin
                    s_d.resp_err = pio_err_pkg::ERR_UNCORR;
                end else if (has_ce) begin
                    s_d.resp_err = pio_err_pkg::ERR_CORR;
                end
            end
        end
        if (set_bits[pio_err_pkg::BIT_DMA_FIFO_UE] && !fatal) begin
            s_d.dma_cancel = 1'b1;
        end
        if (any_new && !fatal && s_q.error_irq_enable) begin
            s_d.trap        = 1'b1;
            s_d.core_status = has_ue ? pio_err_pkg::ERR_UNCORR : pio_err_pkg::ERR_CORR;
        end

        // Read data appear the cycle after the strobe
        if (i_rd) begin
            case (i_addr)
                pio_err_pkg::OFF_STAT_LO:  s_d.rdata = s_q.soc_error_status[31:0];
                pio_err_pkg::OFF_STAT_HI:  s_d.rdata = s_q.soc_error_status[63:32];
                pio_err_pkg::OFF_FATAL_LO: s_d.rdata = s_q.fatal_en[31:0];
                pio_err_pkg::OFF_FATAL_HI: s_d.rdata = s_q.fatal_en[63:32];
                pio_err_pkg::OFF_EIE:      s_d.rdata = {31'h0, s_q.error_irq_enable};
                pio_err_pkg::OFF_USYN0:    s_d.rdata = s_q.usyn_addr[31:0];
                pio_err_pkg::OFF_USYN1:    s_d.rdata = {s_q.usyn_tag[4:0], s_q.usyn_thread,
                                                        s_q.usyn_cpu, s_q.usyn_type,
                                                        s_q.usyn_etag, s_q.usyn_addr[39:32]};
                pio_err_pkg::OFF_ISYN0:    s_d.rdata = s_q.isyn_addr[31:0];
                pio_err_pkg::OFF_ISYN1:    s_d.rdata = {s_q.isyn_tag, s_q.isyn_etag,
                                                        s_q.isyn_addr[39:32]};
                pio_err_pkg::OFF_ISYN2:    s_d.rdata = {16'h0, s_q.usyn_tag};
                default:                   s_d.rdata = 32'h0;
            endcase
        end
    end

    // ========================================
    // Registers
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            s_q                  <= '0;
            s_q.soc_error_status <= pio_err_pkg::STAT_RST;
            s_q.fatal_en         <= pio_err_pkg::FATAL_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_rdata             = s_q.rdata;
    assign o_resp_valid        = s_q.resp_valid;
    assign o_resp_is_ack       = s_q.resp_is_ack;
    assign o_resp_err          = s_q.resp_err;
    assign o_resp_cpu          = s_q.resp_cpu;
    assign o_resp_thread       = s_q.resp_thread;
    assign o_dma_cancel        = s_q.dma_cancel;
    // Warm reset is sticky: only the chip reset that it triggers clears it
    assign o_warm_reset        = s_q.warm_reset;
    assign o_trap              = s_q.trap;
    assign o_core_error_status = s_q.core_status;
endmodule // pio_error_detect_log

// File: pio_err_pkg.sv
// Package with constants for the PIO error detect and log block
package pio_err_pkg;
    // ========================================
    // Error status bit positions
    localparam int STAT_W             = 64;
    localparam int BIT_IFACE_UE       = 1;
    localparam int BIT_UNIT_TAG_CE    = 2;
    localparam int BIT_IFACE_TAG_CE   = 3;
    localparam int BIT_DATA_PAR       = 14;
    localparam int BIT_DISPATCH_PAR   = 15;
    localparam int BIT_REQ_DATA_PAR   = 18;
    localparam int BIT_REQ_UE         = 19;
    localparam int BIT_RET_FIFO_UE    = 20;
    localparam int BIT_DMA_FIFO_UE    = 21;
    localparam int BIT_TAG_UE         = 22;
    localparam int BIT_TOKEN_PAR      = 42;
    // ========================================
    // Incoming interface packet flag positions
    localparam int PKT_W              = 32;
    localparam int PKT_DMA_UE         = 29;
    localparam int PKT_UNMAPPED       = 30;
    localparam int PKT_TIMEOUT        = 31;
    // ========================================
    // Widths, register offsets and reset values
    localparam int PA_W               = 40;
    localparam int TAG_W              = 16;
    localparam int ETAG_W             = 8;
    localparam int RQ_W               = 5;
    localparam int CPU_W              = 3;
    localparam int THR_W              = 3;
    localparam int ADDR_W             = 4;
    localparam logic [3:0] OFF_STAT_LO  = 4'h0;
    localparam logic [3:0] OFF_STAT_HI  = 4'h1;
    localparam logic [3:0] OFF_FATAL_LO = 4'h2;
    localparam logic [3:0] OFF_FATAL_HI = 4'h3;
    localparam logic [3:0] OFF_EIE      = 4'h4;
    localparam logic [3:0] OFF_USYN0    = 4'h5;
    localparam logic [3:0] OFF_USYN1    = 4'h6;
    localparam logic [3:0] OFF_ISYN0    = 4'h7;
    localparam logic [3:0] OFF_ISYN1    = 4'h8;
    localparam logic [3:0] OFF_ISYN2    = 4'h9;
    localparam logic [63:0] STAT_RST    = 64'h0;
    localparam logic [63:0] FATAL_RST   = 64'h0;
    // ========================================
    // Response codes
    localparam logic [1:0] ERR_NONE   = 2'h0;
    localparam logic [1:0] ERR_CORR   = 2'h1;
    localparam logic [1:0] ERR_UNCORR = 2'h2;
endpackage

// File: pio_err_class.sv
// Combinational classifier: maps one cycle's request, return and token error inputs to status bits
`timescale 1ns/10ps
module pio_err_class (
    input  wire logic        i_is_load,
    input  wire logic        i_is_store,
    input  wire logic        i_req_ue,
    input  wire logic        i_req_data_par,
    input  wire logic        i_dma_fifo_par,
    input  wire logic        i_ret_fifo_err,
    input  wire logic        i_ret_valid,
    input  wire logic        i_iface_ue,
    input  wire logic        i_iface_tag_ce,
    input  wire logic        i_tag_ue,
    input  wire logic        i_tag_ce,
    input  wire logic        i_data_par,
    input  wire logic        i_dispatch_par,
    input  wire logic        i_token_valid,
    input  wire logic        i_token_par,
    input  wire logic [31:0] i_pkt,
    output logic      [63:0] o_set,
    output logic             o_pkt_ue
);
    logic any_req;

    assign any_req = i_is_load | i_is_store;

    always_comb begin
        o_set = '0;
        o_set[pio_err_pkg::BIT_REQ_UE]       = any_req & i_req_ue;
        o_set[pio_err_pkg::BIT_REQ_DATA_PAR] = any_req & i_req_data_par;
        o_set[pio_err_pkg::BIT_DMA_FIFO_UE]  = any_req & i_dma_fifo_par;
        o_set[pio_err_pkg::BIT_RET_FIFO_UE]  = i_ret_fifo_err;
        o_set[pio_err_pkg::BIT_IFACE_UE]     = i_ret_valid & i_iface_ue;
        o_set[pio_err_pkg::BIT_IFACE_TAG_CE] = i_ret_valid & i_iface_tag_ce;
        o_set[pio_err_pkg::BIT_TAG_UE]       = i_ret_valid & i_tag_ue;
        o_set[pio_err_pkg::BIT_UNIT_TAG_CE]  = i_ret_valid & i_tag_ce;
        o_set[pio_err_pkg::BIT_DATA_PAR]     = i_ret_valid & i_data_par;
        o_set[pio_err_pkg::BIT_DISPATCH_PAR] = i_is_load & i_dispatch_par;
        o_set[pio_err_pkg::BIT_TOKEN_PAR]    = i_token_valid & i_token_par;
        // Packet flags are reported but never logged
        o_pkt_ue = i_ret_valid & (i_pkt[pio_err_pkg::PKT_TIMEOUT] |
                   i_pkt[pio_err_pkg::PKT_UNMAPPED] | i_pkt[pio_err_pkg::PKT_DMA_UE]);
    end
endmodule // pio_err_class

// File: pio_err_checker_properties.sv
// Concurrent checks on the ports of the PIO error detect and log block
`timescale 1ns/10ps
module pio_err_checker (
    input wire logic        i_sys_clk,
    input wire logic        i_reset_n,
    input wire logic        i_req_valid,
    input wire logic        i_req_ue,
    input wire logic        i_dma_fifo_par,
    input wire logic        i_ret_valid,
    input wire logic [31:0] i_ret_pkt,
    input wire logic        i_iface_ue,
    input wire logic        i_tag_ue,
    input wire logic        i_ret_fifo_err,
    input wire logic        o_resp_valid,
    input wire logic [1:0]  o_resp_err,
    input wire logic        o_dma_cancel,
    input wire logic        o_warm_reset,
    input wire logic        o_trap
);
    // ========================================
    // Properties
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_reset_n);
    // A request with a parity error in the same cycle would own the response slot, so keep it out
    sequence ret_alone;
        i_ret_valid && !i_req_valid && !i_ret_fifo_err;
    endsequence
    sequence quiet;
        !o_resp_valid;
    endsequence
    cancel_on_par_a: assert property (
        i_req_valid && i_dma_fifo_par |=> o_dma_cancel)
        else $error("Request FIFO parity did not cancel the DMA request");
    cancel_cause_a: assert property (
        o_dma_cancel |-> $past(i_req_valid) && $past(i_dma_fifo_par))
        else $error("DMA cancel without a request FIFO parity error");
    req_ue_silent_a: assert property (
        i_req_valid && i_req_ue && !i_ret_valid |=> quiet)
        else $error("Response sent after command field error");
    iface_ue_silent_a: assert property (ret_alone ##0 i_iface_ue |=> quiet)
        else $error("Response sent after interface tag error");
    tag_ue_silent_a: assert property (ret_alone ##0 i_tag_ue |=> quiet)
        else $error("Return packet sent after unit tag error");
    fifo_silent_a: assert property (i_ret_fifo_err |=> quiet)
        else $error("Response sent after output FIFO error");
    pkt_ue_a: assert property (
        ret_alone ##0 (|i_ret_pkt[31:29] && !i_iface_ue && !i_tag_ue && !o_warm_reset)
        |=> o_resp_valid && o_resp_err == pio_err_pkg::ERR_UNCORR)
        else $error("Packet error flags not reported as uncorrectable");
    warm_hold_a: assert property (o_warm_reset |=> o_warm_reset)
        else $error("Warm reset request dropped");
    fatal_quiet_a: assert property (
        $rose(o_warm_reset) |-> !o_trap && !o_resp_valid)
        else $error("Fatal error still answered or trapped");
endmodule // pio_err_checker

bind pio_error_detect_log pio_err_checker chk_u (.*);

// File: io_return_model.sv
// Behavioural model of the I/O interface and DMA return side
`timescale 1ns/10ps
module io_return_model #(
    parameter logic [39:0] RET_ADDR = 40'h0a_5a5a_5a5c
) (
    input  wire logic        i_sys_clk,
    input  wire logic        i_go,
    input  wire logic [3:0]  i_sel,
    output logic             o_ret_valid,
    output logic      [7:0]  o_ret_etag,
    output logic      [15:0] o_ret_tag,
    output logic      [39:0] o_ret_addr,
    output logic      [31:0] o_ret_pkt,
    output logic      [9:0]  o_flag
);
    // ========================================
    // One event per go: sel 0..7 are returns, 8 output FIFO fault, 9 token
    initial begin
        o_ret_valid = 1'b0;
        o_ret_etag = 8'h0;
        o_ret_tag = 16'h0;
        o_ret_addr = 40'h0;
        o_ret_pkt = 32'h0;
        o_flag = 10'h0;
    end
    // Idle data lines toggle so a stale value can never pass for a live one
    always @(posedge i_sys_clk) begin
        o_ret_valid <= i_go && (i_sel < 4'h8);
        o_ret_etag <= i_go ? 8'h3c : ~o_ret_etag;
        o_ret_tag <= i_go ? 16'h1234 : ~o_ret_tag;
        o_ret_addr <= i_go ? RET_ADDR : ~o_ret_addr;
        o_ret_pkt <= i_go ? {i_sel == 4'h5, i_sel == 4'h6, i_sel == 4'h7, 29'h0}
                          : ~o_ret_pkt;
        o_flag <= i_go ? (10'h1 << i_sel) : 10'h0;
    end
endmodule // io_return_model

// File: tb_pio_error_detect_log.sv
// Self-checking testbench for the PIO error detect and log block
`timescale 1ns/10ps
module tb_pio_error_detect_log;
    logic i_sys_clk, i_reset_n, i_req_valid, i_req_is_store, i_req_ue, i_req_data_par;
    logic i_dma_fifo_par, i_dispatch_par, i_ret_valid, i_iface_ue, i_iface_tag_ce, i_tag_ue;
    logic i_tag_ce, i_data_par, i_ret_fifo_err, i_token_valid, i_token_par, i_wr, i_rd;
    logic o_resp_valid, o_resp_is_ack, o_dma_cancel, o_warm_reset, o_trap, go, sc, tr, ak;
    logic [1:0] o_resp_err, o_core_error_status;
    logic [2:0] i_req_cpu, i_req_thread, o_resp_cpu, o_resp_thread, sr;
    logic [3:0] i_addr, sel, rq;
    logic [4:0] i_req_type;
    logic [5:0] cp;
    logic [7:0] i_req_etag, i_ret_etag;
    logic [9:0] flag;
    logic [15:0] i_ret_tag;
    logic [31:0] i_ret_pkt, i_wdata, o_rdata, v;
    logic [39:0] i_req_addr, i_ret_addr;
    logic [63:0] acc;
    int miscompares, n_tests, k;
    localparam logic [39:0] RET_ADDR = 40'h0a_5a5a_5a5c;

    pio_error_detect_log dut_u (.*);
    io_return_model #(.RET_ADDR(RET_ADDR)) io_u (.i_sys_clk(i_sys_clk), .i_go(go), .i_sel(sel),
        .o_ret_valid(i_ret_valid), .o_ret_etag(i_ret_etag), .o_ret_tag(i_ret_tag),
        .o_ret_addr(i_ret_addr), .o_ret_pkt(i_ret_pkt), .o_flag(flag));
    assign {i_token_par, i_ret_fifo_err, i_iface_tag_ce, i_tag_ce, i_data_par, i_tag_ue,
        i_iface_ue} = {flag[9:8], flag[4:0]};
    assign i_token_valid = flag[9];
    assign {i_req_ue, i_req_data_par, i_dma_fifo_par, i_dispatch_par} = rq;
    always #4 i_sys_clk = ~i_sys_clk;

    // ========================================
    // Tasks
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge i_sys_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_sys_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge i_sys_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_sys_clk);
        i_rd <= 1'b0;
        @(negedge i_sys_clk);
        d = o_rdata;
    endtask
    task automatic clr();
        wr(pio_err_pkg::OFF_STAT_LO, 32'hffff_ffff);
        wr(pio_err_pkg::OFF_STAT_HI, 32'hffff_ffff);
        acc = 64'h0;
    endtask
    // One event, a watch window for the answer, then the whole status word
    // er is {valid, err}; 3'b111 leaves the answer unchecked
    task automatic run(input logic ret, input logic st, input logic [3:0] s, input int b,
                       input logic [2:0] er);
        @(posedge i_sys_clk);
        if (ret) begin
            go <= 1'b1;
            sel <= s;
        end else begin
            i_req_valid <= 1'b1;
            i_req_is_store <= st;
            rq <= s;
        end
        @(posedge i_sys_clk);
        go <= 1'b0;
        i_req_valid <= 1'b0;
        rq <= 4'h0;
        {sr, sc, tr, ak, cp} = 12'h0;
        repeat (6) begin
            @(negedge i_sys_clk);
            if (o_resp_valid === 1'b1) begin
                sr = {1'b1, o_resp_err};
                ak = o_resp_is_ack;
                cp = {o_resp_cpu, o_resp_thread};
            end
            sc |= (o_dma_cancel === 1'b1);
            tr |= (o_trap === 1'b1);
        end
        if (er != 3'b111) chk(sr, er);
        if (b >= 0) acc[b] = 1'b1;
        rd(pio_err_pkg::OFF_STAT_LO, v);
        chk(v, acc[31:0]);
        rd(pio_err_pkg::OFF_STAT_HI, v);
        chk(v, acc[63:32]);
    endtask
    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // ========================================
    // Main sequence
    initial begin
        #200000;
        miscompares++;
        final_report();
    end
    initial begin
        i_sys_clk = 1'b0;
        i_reset_n = 1'b0;
        {i_req_valid, i_req_is_store, i_wr, i_rd, go} = 5'h0;
        {rq, sel, i_addr} = 12'h0;
        i_wdata = 32'h0;
        {i_req_etag, i_req_type, i_req_cpu, i_req_thread} = {8'h5a, 5'h11, 3'h5, 3'h2};
        i_req_addr = 40'h12_3456_789a;
        acc = 64'h0;
        repeat (10) @(posedge i_sys_clk);
        i_reset_n <= 1'b1;
        run(1'b0, 1'b0, 4'h2, 21, 3'b110);
        chk({sc, cp}, 7'h6a);
        rd(pio_err_pkg::OFF_USYN0, v);
        chk(v, 32'h3456_789a);
        rd(pio_err_pkg::OFF_USYN1, v);
        chk(v, {5'h0, 3'h2, 3'h5, 5'h11, 8'h5a, 8'h12});
        run(1'b0, 1'b1, 4'h2, 21, 3'b100);
        chk({sc, ak}, 2'b11);
        run(1'b0, 1'b0, 4'h1, 15, 3'b110);
        chk(tr, 1'b0);
        run(1'b0, 1'b0, 4'h4, 18, 3'b100);
        run(1'b0, 1'b1, 4'h4, 18, 3'b110);
        run(1'b0, 1'b0, 4'h8, 19, 3'b000);
        clr();
        $display("Request error test done");
        run(1'b1, 1'b0, 4'h0, 1, 3'b000);
        rd(pio_err_pkg::OFF_ISYN0, v);
        chk(v, RET_ADDR[31:0]);
        rd(pio_err_pkg::OFF_ISYN1, v);
        chk(v, {16'h1234, 8'h3c, RET_ADDR[39:32]});
        run(1'b1, 1'b0, 4'h1, 22, 3'b000);
        rd(pio_err_pkg::OFF_ISYN2, v);
        chk(v, 32'h0000_1234);
        run(1'b1, 1'b0, 4'h2, 14, 3'b110);
        chk(cp, 6'h2a);
        run(1'b1, 1'b0, 4'h3, 2, 3'b101);
        run(1'b1, 1'b0, 4'h4, 3, 3'b101);
        for (k = 5; k < 8; k++) begin
            run(1'b1, 1'b0, k[3:0], -1, 3'b110);
        end
        run(1'b1, 1'b0, 4'h8, 20, 3'b000);
        run(1'b1, 1'b0, 4'h9, 42, 3'b111);
        chk(o_warm_reset, 1'b0);
        wr(4'hf, 32'hffff_ffff);
        rd(4'hf, v);
        chk(v, 32'h0);
        rd(pio_err_pkg::OFF_STAT_LO, v);
        chk(v, acc[31:0]);
        clr();
        $display("Return error test done");
        wr(pio_err_pkg::OFF_EIE, 32'h1);
        run(1'b0, 1'b0, 4'h1, 15, 3'b110);
        chk({tr, o_core_error_status}, {1'b1, pio_err_pkg::ERR_UNCORR});
        run(1'b1, 1'b0, 4'h3, 2, 3'b101);
        chk({tr, o_core_error_status}, {1'b1, pio_err_pkg::ERR_CORR});
        clr();
        wr(pio_err_pkg::OFF_FATAL_LO, 32'h0000_8000);
        rd(pio_err_pkg::OFF_FATAL_LO, v);
        chk(v, 32'h0000_8000);
        run(1'b0, 1'b0, 4'h1, 15, 3'b000);
        chk({tr, o_warm_reset}, 2'b01);
        i_reset_n <= 1'b0;
        repeat (2) @(posedge i_sys_clk);
        i_reset_n <= 1'b1;
        acc = 64'h0;
        chk(o_warm_reset, 1'b0);
        wr(pio_err_pkg::OFF_FATAL_LO, 32'h0004_0000);
        run(1'b0, 1'b1, 4'h4, 18, 3'b000);
        chk(o_warm_reset, 1'b1);
        $display("Trap and fatal test done");
        final_report();
    end
endmodule // tb_pio_error_detect_log
